// ---- radio_state_after_packet_ctrl.sv ----
// Radio control state machine with post-packet exits, channel check and calibration policy
// Assumes an AXI4-Lite master on aclk, command and event pulses on aclk, signal strength from a pin
//
// Notes on behaviour
// - Policy 0 always, 1 rssi, 2 not receiving, 3 both
// - Channel free output follows policy; bits 5:4, reset 3
// - Receive exit field picks state after reception
// - Transmit exit field picks state after transmission
// - Staying in transmit restarts preamble immediately
// - Calibration field bits 5:4 steers self calibration
// - Policy 0 calibrates only on host strobe
// - Policy 1 calibrates when leaving idle
// - Policy 2 calibrates on automatic return to idle
// - Policy 3 calibrates every fourth automatic return
`timescale 1ns/1ps
`include "radio_ctrl_defines.svh"

module radio_state_after_packet_ctrl (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic                         ce,
    input  wire logic [7:0]                   awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [7:0]                   araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    input  wire logic                         rx_cmd,
    input  wire logic                         tx_cmd,
    input  wire logic                         fs_on_cmd,
    input  wire logic                         idle_cmd,
    input  wire logic                         synth_calibrate_strobe,
    input  wire logic                         rx_packet_done,
    input  wire logic                         tx_packet_done,
    input  wire logic                         rx_packet_active,
    input  wire logic                         rssi_below_pin,
    output logic                              channel_free_indication,
    output radio_ctrl_pkg::radio_state_e      radio_state,
    output logic                              synth_cal_start,
    output logic                              preamble_restart
);

    localparam logic [1:0] SEL_NONE   = 2'h0;
    localparam logic [1:0] SEL_EXIT   = 2'h1;
    localparam logic [1:0] SEL_CAL    = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;

    // Only aligned word addresses hit a register
    function automatic logic [1:0] reg_sel(input logic [7:0] addr);
        logic [1:0] sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr[7:2] == `EXIT_CFG_IDX) begin
                sel = SEL_EXIT;
            end else if (addr[7:2] == `CAL_CFG_IDX) begin
                sel = SEL_CAL;
            end else if (addr[7:2] == `STATUS_IDX) begin
                sel = SEL_STATUS;
            end
        end
        return sel;
    endfunction

    // Register file
    radio_ctrl_pkg::exit_cfg_s exit_cfg_ff;
    radio_ctrl_pkg::exit_cfg_s nxt_exit_cfg;
    radio_ctrl_pkg::autocal_e  autocal_ff;
    radio_ctrl_pkg::autocal_e  nxt_autocal;

    // Write channel state
    logic        aw_held_ff;
    logic        nxt_aw_held;
    logic [7:0]  aw_addr_ff;
    logic [7:0]  nxt_aw_addr;
    logic        w_held_ff;
    logic        nxt_w_held;
    logic [31:0] w_data_ff;
    logic [31:0] nxt_w_data;
    logic        w_lane0_ff;
    logic        nxt_w_lane0;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;

    // Read channel state
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;

    // Radio state
    radio_ctrl_pkg::radio_state_e state_ff;
    radio_ctrl_pkg::radio_state_e nxt_state;
    logic        cal_start_ff;
    logic        nxt_cal_start;
    logic        preamble_ff;
    logic        nxt_preamble;
    logic        free_ff;
    logic        nxt_free;
    logic        rssi_sync1_ff;
    logic        rssi_sync2_ff;
    logic        leave_idle;
    logic        auto_to_idle;
    logic        cal_trigger;
    logic        free_now;

    assign awready = ce && !aw_held_ff && !bvalid_ff;
    assign wready  = ce && !w_held_ff && !bvalid_ff;
    assign arready = ce && !rvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;

    assign channel_free_indication = free_ff;
    assign radio_state             = state_ff;
    assign synth_cal_start         = cal_start_ff;
    assign preamble_restart        = preamble_ff;

    // Address and data may arrive in either order; the write lands once both are held
    always_comb begin
        nxt_aw_held  = aw_held_ff;
        nxt_aw_addr  = aw_addr_ff;
        nxt_w_held   = w_held_ff;
        nxt_w_data   = w_data_ff;
        nxt_w_lane0  = w_lane0_ff;
        nxt_bvalid   = bvalid_ff;
        nxt_bresp    = bresp_ff;
        nxt_exit_cfg = exit_cfg_ff;
        nxt_autocal  = autocal_ff;
        if (awvalid && awready) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_held  = 1'b1;
            nxt_w_data  = wdata;
            nxt_w_lane0 = wstrb[0];
        end
        if (aw_held_ff && w_held_ff) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = `RESP_OKAY;
            unique case (reg_sel(aw_addr_ff))
                SEL_EXIT: begin
                    if (w_lane0_ff) begin
                        nxt_exit_cfg = w_data_ff[`POLICY_MSB:`TX_NEXT_LSB];
                    end
                end
                SEL_CAL: begin
                    if (w_lane0_ff) begin
                        nxt_autocal = radio_ctrl_pkg::autocal_e'(w_data_ff[`AUTOCAL_MSB:`AUTOCAL_LSB]);
                    end
                end
                SEL_STATUS: nxt_bresp = `RESP_OKAY;
                SEL_NONE:   nxt_bresp = `RESP_SLVERR;
            endcase
        end else if (bvalid_ff && bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    // Reads answer one cycle after the address is taken
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (arvalid && arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `RESP_OKAY;
            nxt_rdata  = 32'h0;
            unique case (reg_sel(araddr))
                SEL_EXIT:   nxt_rdata[`POLICY_MSB:`TX_NEXT_LSB] = exit_cfg_ff;
                SEL_CAL:    nxt_rdata[`AUTOCAL_MSB:`AUTOCAL_LSB] = autocal_ff;
                SEL_STATUS: nxt_rdata[`STATUS_FREE_BIT:0] = {free_ff, state_ff};
                SEL_NONE:   nxt_rresp = `RESP_SLVERR;
            endcase
        end else if (rvalid_ff && rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff  <= 1'b0;
            aw_addr_ff  <= 8'h00;
            w_held_ff   <= 1'b0;
            w_data_ff   <= 32'h0000_0000;
            w_lane0_ff  <= 1'b0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= `RESP_OKAY;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            rresp_ff    <= `RESP_OKAY;
            exit_cfg_ff <= `EXIT_CFG_RESET;
            autocal_ff  <= radio_ctrl_pkg::cal_never;
        end else if (ce) begin
            aw_held_ff  <= nxt_aw_held;
            aw_addr_ff  <= nxt_aw_addr;
            w_held_ff   <= nxt_w_held;
            w_data_ff   <= nxt_w_data;
            w_lane0_ff  <= nxt_w_lane0;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            rvalid_ff   <= nxt_rvalid;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
            exit_cfg_ff <= nxt_exit_cfg;
            autocal_ff  <= nxt_autocal;
        end
    end

    clear_channel_eval u_clear_channel_eval (
        .clear_channel_policy    (exit_cfg_ff.clear_channel_policy),
        .rssi_below              (rssi_sync2_ff),
        .rx_packet_active        (rx_packet_active),
        .channel_free_indication (free_now)
    );

    autocal_trigger u_autocal_trigger (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .ce                   (ce),
        .synth_autocal_policy (autocal_ff),
        .leave_idle           (leave_idle),
        .auto_to_idle         (auto_to_idle),
        .cal_trigger          (cal_trigger)
    );

    // Main state machine; commands from other states are ignored
    always_comb begin
        nxt_state    = state_ff;
        nxt_preamble = 1'b0;
        auto_to_idle = 1'b0;
        unique case (state_ff)
            radio_ctrl_pkg::st_idle: begin
                if (rx_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_rx;
                end else if (tx_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_tx;
                end else if (fs_on_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_fs_ready;
                end
            end
            radio_ctrl_pkg::st_rx: begin
                if (rx_packet_done) begin
                    unique case (exit_cfg_ff.after_receive_next_state)
                        `NEXT_IDLE: begin
                            nxt_state    = radio_ctrl_pkg::st_idle;
                            auto_to_idle = 1'b1;
                        end
                        `NEXT_FS_READY: nxt_state = radio_ctrl_pkg::st_fs_ready;
                        `RX_NEXT_TX:    nxt_state = radio_ctrl_pkg::st_tx;
                        `RX_NEXT_STAY:  nxt_state = radio_ctrl_pkg::st_rx;
                    endcase
                end else if (idle_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_idle;
                end
            end
            radio_ctrl_pkg::st_tx: begin
                if (tx_packet_done) begin
                    unique case (exit_cfg_ff.after_transmit_next_state)
                        `NEXT_IDLE: begin
                            nxt_state    = radio_ctrl_pkg::st_idle;
                            auto_to_idle = 1'b1;
                        end
                        `NEXT_FS_READY: nxt_state = radio_ctrl_pkg::st_fs_ready;
                        `TX_NEXT_STAY: begin
                            nxt_state    = radio_ctrl_pkg::st_tx;
                            nxt_preamble = 1'b1;
                        end
                        `TX_NEXT_RX:    nxt_state = radio_ctrl_pkg::st_rx;
                    endcase
                end else if (idle_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_idle;
                end
            end
            radio_ctrl_pkg::st_fs_ready: begin
                if (rx_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_rx;
                end else if (tx_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_tx;
                end else if (idle_cmd) begin
                    nxt_state = radio_ctrl_pkg::st_idle;
                end
            end
            default: nxt_state = radio_ctrl_pkg::st_idle;
        endcase
    end

    assign leave_idle = (state_ff == radio_ctrl_pkg::st_idle) && (nxt_state != radio_ctrl_pkg::st_idle);

    // Manual strobe only honoured in idle, where the synthesizer is free
    always_comb begin
        nxt_cal_start = cal_trigger || (synth_calibrate_strobe && state_ff == radio_ctrl_pkg::st_idle);
        nxt_free      = free_now;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff      <= radio_ctrl_pkg::st_idle;
            cal_start_ff  <= 1'b0;
            preamble_ff   <= 1'b0;
            free_ff       <= 1'b0;
            rssi_sync1_ff <= 1'b0;
            rssi_sync2_ff <= 1'b0;
        end else if (ce) begin
            state_ff      <= nxt_state;
            cal_start_ff  <= nxt_cal_start;
            preamble_ff   <= nxt_preamble;
            free_ff       <= nxt_free;
            rssi_sync1_ff <= rssi_below_pin;
            rssi_sync2_ff <= rssi_sync1_ff;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rx_done_stay;
        ce && state_ff == radio_ctrl_pkg::st_rx && rx_packet_done
            && exit_cfg_ff.after_receive_next_state == `RX_NEXT_STAY;
    endsequence

    sequence s_tx_done_idle;
        ce && state_ff == radio_ctrl_pkg::st_tx && tx_packet_done
            && exit_cfg_ff.after_transmit_next_state == `NEXT_IDLE;
    endsequence

    sequence s_tx_done_stay;
        ce && state_ff == radio_ctrl_pkg::st_tx && tx_packet_done
            && exit_cfg_ff.after_transmit_next_state == `TX_NEXT_STAY;
    endsequence

    a_free_always: assert property (ce && exit_cfg_ff.clear_channel_policy == `CHAN_ALWAYS |=> free_ff)
        else $error("Channel not free under always policy");

    a_free_both: assert property (ce && exit_cfg_ff.clear_channel_policy == `CHAN_BOTH
        |=> free_ff == ($past(rssi_sync2_ff) && !$past(rx_packet_active)))
        else $error("Channel free disagrees with combined policy");

    a_rx_stays: assert property (s_rx_done_stay |=> state_ff == radio_ctrl_pkg::st_rx)
        else $error("Receive exit did not stay in receive");

    a_tx_to_idle: assert property (s_tx_done_idle |=> state_ff == radio_ctrl_pkg::st_idle)
        else $error("Transmit exit did not return to idle");

    a_tx_preamble: assert property (s_tx_done_stay |=> state_ff == radio_ctrl_pkg::st_tx && preamble_ff)
        else $error("No preamble restart after staying in transmit");

    a_never_auto: assert property (ce && autocal_ff == radio_ctrl_pkg::cal_never && !synth_calibrate_strobe
        |=> !cal_start_ff)
        else $error("Self calibration while policy forbids it");

    a_leave_idle_cal: assert property (ce && autocal_ff == radio_ctrl_pkg::cal_leave_idle
        && state_ff == radio_ctrl_pkg::st_idle && (rx_cmd || tx_cmd || fs_on_cmd) |=> cal_start_ff)
        else $error("No calibration when leaving idle");

    a_auto_idle_cal: assert property ((s_tx_done_idle and autocal_ff == radio_ctrl_pkg::cal_auto_idle)
        |=> cal_start_ff && state_ff == radio_ctrl_pkg::st_idle)
        else $error("No calibration on automatic return to idle");

    a_reserved_zero: assert property (rvalid_ff |-> rdata_ff[31:6] == 26'h0)
        else $error("Reserved read bits not zero");

endmodule

// ---- radio_ctrl_defines.svh ----
// Register indices, field positions, reset values and codes of the radio control block
// Assumes inclusion by bare name from any file that needs them
`ifndef RADIO_CTRL_DEFINES_SVH
`define RADIO_CTRL_DEFINES_SVH

// Register indices; byte address is four times the index
`define EXIT_CFG_IDX        6'h16
`define CAL_CFG_IDX         6'h17
`define STATUS_IDX          6'h18

// Field positions
`define POLICY_MSB          5
`define POLICY_LSB          4
`define RX_NEXT_MSB         3
`define RX_NEXT_LSB         2
`define TX_NEXT_MSB         1
`define TX_NEXT_LSB         0
`define AUTOCAL_MSB         5
`define AUTOCAL_LSB         4
`define STATUS_FREE_BIT     4

// Reset values
`define EXIT_CFG_RESET      6'h30
`define AUTOCAL_RESET       2'h0

// Clear channel policy codes
`define CHAN_ALWAYS         2'h0
`define CHAN_RSSI_LOW       2'h1
`define CHAN_NOT_RECEIVING  2'h2
`define CHAN_BOTH           2'h3

// Next state codes after a packet
`define NEXT_IDLE           2'h0
`define NEXT_FS_READY       2'h1
`define RX_NEXT_TX          2'h2
`define RX_NEXT_STAY        2'h3
`define TX_NEXT_STAY        2'h2
`define TX_NEXT_RX          2'h3

// Bus answers
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ---- radio_ctrl_pkg.sv ----
// Types shared by the radio control block
// Assumes the constants header for field codes
package radio_ctrl_pkg;

    typedef enum logic [3:0] {
        st_idle     = 4'h1,
        st_rx       = 4'h2,
        st_tx       = 4'h4,
        st_fs_ready = 4'h8
    } radio_state_e;

    typedef enum logic [1:0] {
        cal_never        = 2'h0,
        cal_leave_idle   = 2'h1,
        cal_auto_idle    = 2'h2,
        cal_every_fourth = 2'h3
    } autocal_e;

    typedef struct packed {
        logic [1:0] clear_channel_policy;
        logic [1:0] after_receive_next_state;
        logic [1:0] after_transmit_next_state;
    } exit_cfg_s;

endpackage

// ---- clear_channel_eval.sv ----
// Forms the channel free indication from the selected policy
// Assumes synchronised signal strength and same-clock reception activity
`timescale 1ns/1ps
`include "radio_ctrl_defines.svh"

module clear_channel_eval (
    input  wire logic [1:0] clear_channel_policy,
    input  wire logic       rssi_below,
    input  wire logic       rx_packet_active,
    output logic            channel_free_indication
);

    always_comb begin
        unique case (clear_channel_policy)
            `CHAN_ALWAYS:        channel_free_indication = 1'b1;
            `CHAN_RSSI_LOW:      channel_free_indication = rssi_below;
            `CHAN_NOT_RECEIVING: channel_free_indication = !rx_packet_active;
            `CHAN_BOTH:          channel_free_indication = rssi_below && !rx_packet_active;
        endcase
    end

endmodule

// ---- autocal_trigger.sv ----
// Decides when the synthesizer calibrates itself
// Assumes one-cycle event pulses from the control state machine on the same clock
`timescale 1ns/1ps
`include "radio_ctrl_defines.svh"

module autocal_trigger (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    input  wire radio_ctrl_pkg::autocal_e synth_autocal_policy,
    input  wire logic                     leave_idle,
    input  wire logic                     auto_to_idle,
    output logic                          cal_trigger
);

    logic [1:0] return_count_ff;
    logic [1:0] nxt_return_count;

    // Counts every automatic return so a policy change keeps the cadence
    always_comb begin
        nxt_return_count = return_count_ff;
        if (auto_to_idle) begin
            nxt_return_count = return_count_ff + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            return_count_ff <= 2'h0;
        end else if (ce) begin
            return_count_ff <= nxt_return_count;
        end
    end

    always_comb begin
        unique case (synth_autocal_policy)
            radio_ctrl_pkg::cal_never:        cal_trigger = 1'b0;
            radio_ctrl_pkg::cal_leave_idle:   cal_trigger = leave_idle;
            radio_ctrl_pkg::cal_auto_idle:    cal_trigger = auto_to_idle;
            radio_ctrl_pkg::cal_every_fourth: cal_trigger = auto_to_idle && (return_count_ff == 2'h3);
        endcase
    end

    a_fourth_return_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (synth_autocal_policy == radio_ctrl_pkg::cal_every_fourth && cal_trigger)
            |-> (auto_to_idle && return_count_ff == 2'h3))
        else $error("Calibration outside the fourth automatic return");

endmodule

// ---- testbench.sv ----
// Self-checking bench for the radio control block, with a reference model
// Assumes the package, constants header and design files are compiled first
`timescale 1ns/1ps
`include "radio_ctrl_defines.svh"

module testbench;
    localparam logic [7:0] EXIT_A = {`EXIT_CFG_IDX, 2'h0};
    localparam logic [7:0] CAL_A  = {`CAL_CFG_IDX, 2'h0};
    localparam logic [7:0] STAT_A = {`STATUS_IDX, 2'h0};
    logic                         aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic                         arvalid = 0, rready = 0, rx_packet_active = 0, rssi_below_pin = 0, ce = 1;
    logic                         awready, wready, bvalid, arready, rvalid;
    logic                         channel_free_indication, synth_cal_start, preamble_restart;
    logic [7:0]                   awaddr = 0, araddr = 0, ra;
    logic [31:0]                  wdata = 0, rdata, rd_val, rv;
    logic [3:0]                   wstrb = 0, rs;
    logic [1:0]                   bresp, rresp, rd_resp;
    logic [6:0]                   ev = 0;
    logic [5:0]                   ecfg = 6'h30, ccfg = 6'h00;
    radio_ctrl_pkg::radio_state_e radio_state;
    int                           errors = 0, total_checks = 0, st = 1, cnt = 0;
    int                           nmap [4] = '{1, 8, 4, 2};

    always #10 aclk = ~aclk;

    radio_state_after_packet_ctrl radio_state_after_packet_ctrl_inst (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .rx_cmd(ev[0]), .tx_cmd(ev[1]), .fs_on_cmd(ev[2]), .idle_cmd(ev[3]),
        .synth_calibrate_strobe(ev[4]), .rx_packet_done(ev[5]), .tx_packet_done(ev[6]),
        .rx_packet_active, .rssi_below_pin, .channel_free_indication, .radio_state,
        .synth_cal_start, .preamble_restart
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Each half released on its own handshake; bready held up from the start
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        chk(32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
        rd_val = rdata;
        rd_resp = rresp;
    endtask

    // One command or event pulse, then outputs compared with the model
    task automatic step(input int k);
        int   ns, ac, sel;
        logic cx, px, back;
        ac = int'(ccfg[5:4]);
        ns = st;
        cx = 0;
        px = 0;
        back = 0;
        @(posedge aclk);
        ev <= 7'h01 << k;
        rssi_below_pin <= 1'($urandom);
        rx_packet_active <= 1'($urandom);
        @(posedge aclk);
        ev <= 0;
        #1;
        case (st)
            1: if (k < 3) begin
                ns = (k == 0) ? 2 : (k == 1) ? 4 : 8;
                cx = (ac == 1);
            end else if (k == 4) cx = 1;
            2, 4: if (k == 5 + st / 4) begin
                sel = (st == 2) ? int'(ecfg[3:2]) : int'(ecfg[1:0]);
                ns = nmap[sel];
                back = (sel == 0);
                px = (st == 4 && sel == 2);
            end else if (k == 3) ns = 1;
            default: if (k == 0) ns = 2;
                else if (k == 1) ns = 4;
                else if (k == 3) ns = 1;
        endcase
        // Counter sees every automatic return, whatever the policy
        if (back) begin
            cx = (ac == 2) || (ac == 3 && cnt == 3);
            cnt = (cnt + 1) % 4;
        end
        chk(32'(radio_state), 32'(ns));
        chk(32'(synth_cal_start), 32'(cx));
        chk(32'(preamble_restart), 32'(px));
        st = ns;
    endtask

    initial begin
        void'($urandom(32'hcce5c8db));
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(EXIT_A);
        chk(rd_val, 32'h30);
        rd(CAL_A);
        chk(rd_val, 32'h0);
        rd(8'h40);
        chk(32'(rd_resp), 32'(`RESP_SLVERR));
        wr(8'h41, 32'hFF, 4'hF, `RESP_SLVERR);
        // Status is read only; a write is answered but changes nothing
        wr(STAT_A, 32'hFF, 4'hF, `RESP_OKAY);
        $display("test reset and map done");
        for (int p = 0; p < 4; p++) begin
            wr(EXIT_A, 32'(p << 4), 4'hF, `RESP_OKAY);
            ecfg = 6'(p << 4);
            for (int i = 0; i < 4; i++) begin
                @(posedge aclk);
                rssi_below_pin <= i[0];
                rx_packet_active <= i[1];
                repeat (4) @(posedge aclk);
                #1;
                chk(32'(channel_free_indication), 32'((!p[0] || i[0]) && (!p[1] || !i[1])));
            end
        end
        $display("test channel policy done");
        for (int n = 0; n < 400; n++) begin
            if ($urandom % 6 == 0) begin
                ra = ($urandom % 2) ? EXIT_A : CAL_A;
                rv = $urandom;
                rs = 4'($urandom);
                if (rv[3:2] == 2'h1 || rv[3:2] == 2'h2) rv[5:4] = 2'h0;
                wr(ra, rv, rs, `RESP_OKAY);
                if (rs[0] && ra == EXIT_A) ecfg = rv[5:0];
                if (rs[0] && ra == CAL_A) ccfg = rv[5:0] & 6'h30;
                rd(ra);
                chk(rd_val, 32'(ra == EXIT_A ? ecfg : ccfg));
                chk(32'(rd_resp), 32'(`RESP_OKAY));
            end else step($urandom % 7);
        end
        // Enable low freezes the state machine and drops the bus readies
        @(posedge aclk);
        ce <= 0;
        ev <= (st == 1) ? 7'h01 : 7'h08;
        @(posedge aclk);
        #1;
        chk(32'(arready), 32'h0);
        chk(32'(radio_state), 32'(st));
        @(posedge aclk);
        ce <= 1;
        ev <= 0;
        rd(STAT_A);
        chk(32'(rd_val[3:0]), 32'(st));
        $display("test state machine done");
        close_out();
    end

    // Runs take under two thousand cycles; this margin only catches a hang
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        close_out();
    end
endmodule
